// ---- include/spe_cfg.svh ----
/*
 * constants of the signal power estimator: sample and power widths,
 * window sizes, output codes and the 1 dB bin thresholds.
 * assumes 12-bit samples and 0 dBFS equal to full-scale sine power.
 */
`ifndef SPE_CFG_SVH
`define SPE_CFG_SVH

`define SPE_SAMPLE_W      12
`define SPE_SQ_W          23
`define SPE_ACC_W         37
`define SPE_CNT_W         14
`define SPE_LEN_W         3
`define SPE_CODE_W        4
`define SPE_SHIFT_W       4

`define SPE_WIN_BASE      14'h0400
`define SPE_WIN_BASE_LOG2 4'ha
`define SPE_LEN_MAX       3'h4
`define SPE_OB_MIDSCALE   12'h800
`define SPE_TC_ZERO       12'h000

`define SPE_CODE_OFF      4'h0
`define SPE_CODE_LOW      4'h1
`define SPE_CODE_TOP      4'he
`define SPE_CODE_BAD      4'hf

`define SPE_NUM_THR       13
// bin edges, -12.5 dBFS upward in 1 dB steps, then -1.5 to 0 dBFS
`define SPE_THR_0         23'h01ccac
`define SPE_THR_1         23'h0243f2
`define SPE_THR_2         23'h02da1b
`define SPE_THR_3         23'h039726
`define SPE_THR_4         23'h0485a4
`define SPE_THR_5         23'h05b0c2
`define SPE_THR_6         23'h072a03
`define SPE_THR_7         23'h0904cf
`define SPE_THR_8         23'h0b5a9e
`define SPE_THR_9         23'h0e4b3b
`define SPE_THR_10        23'h11feef
`define SPE_THR_11        23'h16a775
`define SPE_THR_12        23'h200000

`endif

// ---- include/spe_pkg.sv ----
/*
 * types of the signal power estimator.
 * assumes spe_cfg.svh is on the include path.
 */
`include "spe_cfg.svh"

package spe_pkg;
	typedef logic [`SPE_SAMPLE_W-1:0] spe_sample_t;
	typedef logic [`SPE_SQ_W-1:0]     spe_power_t;
	typedef logic [`SPE_CODE_W-1:0]   spe_code_t;
	typedef logic [`SPE_LEN_W-1:0]    spe_len_t;
	typedef enum logic [1:0] {
		SPE_IDLE,
		SPE_RUN,
		SPE_HALT
	} spe_state_t;
endpackage

// ---- rtl/spe_quantizer.sv ----
/*
 * maps an averaged sample power onto the 4-bit level code, 1 dB bins.
 * assumes one clock, synchronous active-low reset, one-cycle valid.
 */
`timescale 1ns/10ps
`include "spe_cfg.svh"

module spe_quantizer (
	input  wire logic             core_clk,    // conversion clock
	input  wire logic             rst_n,       // sync reset, active low
	input  wire spe_pkg::spe_power_t avg_power,   // window mean power
	input  wire logic             avg_valid,   // mean ready, pulse
	output logic [`SPE_CODE_W-1:0] code_r,      // level code
	output logic                  code_valid_r // code updated, pulse
);
	import spe_pkg::*;

	localparam spe_power_t THR [`SPE_NUM_THR] = '{
		`SPE_THR_0, `SPE_THR_1, `SPE_THR_2, `SPE_THR_3, `SPE_THR_4,
		`SPE_THR_5, `SPE_THR_6, `SPE_THR_7, `SPE_THR_8, `SPE_THR_9,
		`SPE_THR_10, `SPE_THR_11, `SPE_THR_12
	};

	logic [`SPE_NUM_THR-1:0] above;
	spe_code_t               code_nxt;

	genvar i;
	generate
		for (i = 0; i < `SPE_NUM_THR; i++) begin : g_thr
			assign above[i] = (avg_power >= THR[i]);
		end
	endgenerate

	always_comb begin
		code_nxt = `SPE_CODE_LOW;
		for (int k = 0; k < `SPE_NUM_THR; k++) begin
			code_nxt = code_nxt + spe_code_t'(above[k]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			code_r <= `SPE_CODE_LOW;
		end else if (avg_valid) begin
			code_r <= code_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			code_valid_r <= 1'b0;
		end else begin
			code_valid_r <= avg_valid;
		end
	end

	AST_LOW_BIN: assert property (@(posedge core_clk) disable iff (!rst_n)
		avg_valid && (avg_power < `SPE_THR_0) |=> code_valid_r && (code_r == `SPE_CODE_LOW))
		else $error("power below lowest edge did not give code 1");

	AST_MID_BIN: assert property (@(posedge core_clk) disable iff (!rst_n)
		avg_valid && (avg_power >= `SPE_THR_5) && (avg_power < `SPE_THR_6)
		|=> code_r == 4'h7)
		else $error("power in seventh bin gave wrong code");

	AST_TOP_BIN: assert property (@(posedge core_clk) disable iff (!rst_n)
		avg_valid && (avg_power >= `SPE_THR_12) |=> code_r == `SPE_CODE_TOP)
		else $error("power at or above full scale did not give code 1110");
endmodule

// ---- rtl/spe_estimator.sv ----
/*
 * signal power estimator: squares each converted sample, averages over
 * a window of 1K..16K samples and drives the level code on four pins.
 * assumes samples arrive synchronous to core_clk with a one-cycle valid.
 */
`timescale 1ns/10ps
`include "spe_cfg.svh"

// What this block does
// - The level pins carry the power code only while power_estimate_enable is set.
// - The estimate is the mean squared sample over a run of consecutive samples.
// - Power below -12.5 dBFS gives 0001, and each 1 dB bin up to -1.5 dBFS counts up to 1100.
// - Power from -1.5 to 0 dBFS gives 1101 and power at or above 0 dBFS gives 1110.
// - The window field picks 1K, 2K, 4K, 8K or 16K samples for codes 000 to 100.
// - Samples are 12-bit results in offset binary or twos complement as selected.
module spe_estimator (
	input  wire logic             core_clk,              // conversion clock, 40 MHz
	input  wire logic             rst_n,                 // sync reset, active low
	input  wire spe_pkg::spe_sample_t sample_data,       // converted sample
	input  wire logic             sample_valid,          // sample strobe
	input  wire logic             sample_twos_comp,      // 1 twos complement, 0 offset
	input  wire logic             power_estimate_enable, // estimator on
	input  wire spe_pkg::spe_len_t average_window_length, // window size select
	output logic [`SPE_CODE_W-1:0] level_detect_r,       // level pins
	output logic                  level_update_r,        // new code, pulse
	output logic                  window_unsupported_r   // bad window field
);
	import spe_pkg::*;

	spe_state_t                 state_r;
	spe_state_t                 state_nxt;
	spe_len_t                   len_r;
	logic [`SPE_CNT_W-1:0]      cnt_r;
	logic [`SPE_CNT_W-1:0]      win_last;
	logic [`SPE_ACC_W-1:0]      acc_r;
	logic [`SPE_ACC_W-1:0]      acc_sum;
	logic [`SPE_SHIFT_W-1:0]    shift;
	logic signed [`SPE_SAMPLE_W-1:0] s_signed;
	logic signed [2*`SPE_SAMPLE_W-1:0] prod;
	spe_power_t                 sq_r;
	logic                       sq_valid_r;
	spe_power_t                 avg_r;
	logic                       avg_valid_r;
	logic                       len_bad;
	logic                       win_end;
	spe_code_t                  code;
	logic                       code_valid;

	// offset binary flips the sign bit
	assign s_signed = sample_twos_comp ? sample_data
		: {~sample_data[`SPE_SAMPLE_W-1], sample_data[`SPE_SAMPLE_W-2:0]};
	assign prod     = s_signed * s_signed;
	assign len_bad  = (average_window_length > `SPE_LEN_MAX);
	assign win_last = `SPE_CNT_W'(`SPE_WIN_BASE << len_r) - `SPE_CNT_W'(1);
	assign shift    = `SPE_WIN_BASE_LOG2 + {1'b0, len_r};
	assign acc_sum  = acc_r + `SPE_ACC_W'(sq_r);
	assign win_end  = (state_r == SPE_RUN) && sq_valid_r && (cnt_r == win_last);

	// square stage
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sq_r       <= '0;
			sq_valid_r <= 1'b0;
		end else begin
			sq_valid_r <= sample_valid && power_estimate_enable;
			if (sample_valid) begin
				sq_r <= prod[`SPE_SQ_W-1:0];
			end
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SPE_IDLE: begin
				if (power_estimate_enable) begin
					state_nxt = len_bad ? SPE_HALT : SPE_RUN;
				end
			end
			SPE_RUN: begin
				if (!power_estimate_enable) begin
					state_nxt = SPE_IDLE;
				end else if (len_bad) begin
					state_nxt = SPE_HALT;
				end
			end
			SPE_HALT: begin
				if (!power_estimate_enable || !len_bad) begin
					state_nxt = SPE_IDLE;
				end
			end
			default: state_nxt = SPE_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= SPE_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// window field taken only at a window start
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			len_r <= '0;
		end else if ((state_r == SPE_IDLE) || win_end) begin
			len_r <= average_window_length;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			acc_r <= '0;
			cnt_r <= '0;
		end else if (state_r != SPE_RUN || win_end) begin
			acc_r <= '0;
			cnt_r <= '0;
		end else if (sq_valid_r) begin
			acc_r <= acc_sum;
			cnt_r <= cnt_r + `SPE_CNT_W'(1);
		end
	end

	// mean is sum over power-of-two count
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			avg_r       <= '0;
			avg_valid_r <= 1'b0;
		end else begin
			avg_valid_r <= win_end;
			if (win_end) begin
				avg_r <= `SPE_SQ_W'(acc_sum >> shift);
			end
		end
	end

	spe_quantizer u_quant (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.avg_power    (avg_r),
		.avg_valid    (avg_valid_r),
		.code_r       (code),
		.code_valid_r (code_valid)
	);

	// pins zero when off, else held code
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			level_detect_r <= `SPE_CODE_OFF;
			level_update_r <= 1'b0;
		end else if (!power_estimate_enable) begin
			level_detect_r <= `SPE_CODE_OFF;
			level_update_r <= 1'b0;
		end else begin
			level_update_r <= code_valid;
			if (code_valid) begin
				level_detect_r <= code;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			window_unsupported_r <= 1'b0;
		end else begin
			window_unsupported_r <= power_estimate_enable && len_bad;
		end
	end

	// helper: squares seen in the current window
	logic [`SPE_CNT_W:0] seen_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n || state_r != SPE_RUN || win_end) begin
			seen_r <= '0;
		end else if (sq_valid_r) begin
			seen_r <= seen_r + (`SPE_CNT_W+1)'(1);
		end
	end

	AST_OFF_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		!power_estimate_enable |=> (level_detect_r == `SPE_CODE_OFF) && !level_update_r)
		else $error("level pins not cleared while estimator off");

	AST_WINDOW_SPAN: assert property (@(posedge core_clk) disable iff (!rst_n)
		win_end |-> (seen_r + (`SPE_CNT_W+1)'(1)) == ((`SPE_CNT_W+1)'(1) << (len_r + 3'h2) << 8))
		else $error("window closed after wrong number of samples");

	AST_SMALLEST_WIN: assert property (@(posedge core_clk) disable iff (!rst_n)
		win_end && (len_r == 3'h0) |-> seen_r == 15'h03ff)
		else $error("1K window did not span 1024 samples");

	AST_OB_MIDSCALE: assert property (@(posedge core_clk) disable iff (!rst_n)
		sample_valid && !sample_twos_comp && (sample_data == `SPE_OB_MIDSCALE)
		|=> sq_r == '0)
		else $error("offset binary midscale not treated as zero");

	AST_TC_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		sample_valid && sample_twos_comp && (sample_data == `SPE_TC_ZERO) |=> sq_r == '0)
		else $error("twos complement zero not treated as zero");

	AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		power_estimate_enable && !code_valid |=> $stable(level_detect_r))
		else $error("level code moved without a finished window");

	AST_NO_BAD_CODE: assert property (@(posedge core_clk) disable iff (!rst_n)
		power_estimate_enable |=> level_detect_r != `SPE_CODE_BAD)
		else $error("level code 1111 produced");

	AST_BAD_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
		power_estimate_enable && len_bad |=> window_unsupported_r ##1 !avg_valid_r)
		else $error("unsupported window field not flagged or still averaging");
endmodule

// ---- bench/spe_pin_reader.sv ----
/*
 * far-side model: external logic latching the level pins on each update.
 * assumes the estimator's clock and its synchronous active-low reset.
 */
`timescale 1ns/10ps

module spe_pin_reader (
	input  wire logic               core_clk,       // conversion clock
	input  wire logic               rst_n,          // sync reset, active low
	input  wire spe_pkg::spe_code_t level_detect_r, // level pins
	input  wire logic               level_update_r, // new code pulse
	output spe_pkg::spe_code_t      code_seen_r,    // last code taken
	output logic [7:0]              updates_r       // pulses counted
);
	import spe_pkg::*;

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			code_seen_r <= 4'h0;
		else if (level_update_r)
			code_seen_r <= level_detect_r;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			updates_r <= 8'h00;
		else if (level_update_r)
			updates_r <= updates_r + 8'h01;
	end
endmodule

// ---- bench/spe_estimator_tb.sv ----
/*
 * self-checking bench of the power estimator: table of windows, then
 * discard, unsupported field and mid-run reset cases.
 * assumes spe_pkg compiled first and constant samples per window.
 */
`timescale 1ns/10ps

module spe_estimator_tb;
	import spe_pkg::*;
	typedef struct {spe_len_t len; logic tc; spe_sample_t smp; spe_code_t code;} spe_row_t;
	logic        core_clk, rst_n, sample_valid, sample_twos_comp, power_estimate_enable;
	logic        level_update_r, window_unsupported_r;
	spe_sample_t sample_data;
	spe_len_t    average_window_length;
	spe_code_t   level_detect_r, code_seen_r;
	logic [7:0]  updates_r, u0;
	int          fails, comparisons;
	spe_row_t    rows [9] = '{'{3'h0, 1'b1, 12'h000, 4'h1}, '{3'h0, 1'b1, 12'h7ff, 4'he},
		'{3'h0, 1'b1, 12'h5a8, 4'hd}, '{3'h1, 1'b1, 12'h200, 4'h5},
		'{3'h0, 1'b1, 12'h280, 4'h7}, '{3'h0, 1'b0, 12'h800, 4'h1},
		'{3'h2, 1'b0, 12'ha00, 4'h5}, '{3'h3, 1'b0, 12'hb00, 4'h8},
		'{3'h4, 1'b1, 12'hc00, 4'hb}};

	spe_estimator spe_estimator_inst (.core_clk(core_clk), .rst_n(rst_n),
		.sample_data(sample_data), .sample_valid(sample_valid),
		.sample_twos_comp(sample_twos_comp), .power_estimate_enable(power_estimate_enable),
		.average_window_length(average_window_length), .level_detect_r(level_detect_r),
		.level_update_r(level_update_r), .window_unsupported_r(window_unsupported_r));
	spe_pin_reader spe_pin_reader_inst (.core_clk(core_clk), .rst_n(rst_n),
		.level_detect_r(level_detect_r), .level_update_r(level_update_r),
		.code_seen_r(code_seen_r), .updates_r(updates_r));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic stop_test;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic start(input spe_len_t len, input logic tc);
		@(negedge core_clk);
		average_window_length = len;
		sample_twos_comp = tc;
		power_estimate_enable = 1'b1;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic feed(input int n, input spe_sample_t d);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk);
			sample_valid = 1'b1;
			sample_data = d;
		end
		@(negedge core_clk);
		sample_valid = 1'b0;
		sample_data = ~d;
	endtask

	// code appears three edges after the last sample, as a one-cycle pulse
	task automatic expect_update(input spe_code_t exp);
		repeat (2) begin
			@(posedge core_clk);
			#1;
			chk_bit(level_update_r, 1'b0);
		end
		@(posedge core_clk);
		#1;
		chk_bit(level_update_r, 1'b1);
		chk_val(level_detect_r, exp);
		@(posedge core_clk);
		#1;
		chk_bit(level_update_r, 1'b0);
		chk_val(level_detect_r, exp);
	endtask

	task automatic stop_run;
		@(negedge core_clk);
		power_estimate_enable = 1'b0;
		@(posedge core_clk);
		#1;
		chk_val(level_detect_r, 8'h00);
	endtask

	initial begin
		#2000000;
		fails++;
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		sample_data = 12'h000;
		sample_valid = 1'b0;
		sample_twos_comp = 1'b1;
		power_estimate_enable = 1'b0;
		average_window_length = 3'h0;
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		// one window per row, every window length and both formats
		for (int r = 0; r < 9; r++) begin
			start(rows[r].len, rows[r].tc);
			feed(1024 << rows[r].len, rows[r].smp);
			expect_update(rows[r].code);
			stop_run();
		end
		// disabled samples ignored, partial window discarded
		u0 = updates_r;
		feed(300, 12'h7ff);
		start(3'h0, 1'b1);
		feed(500, 12'h7ff);
		stop_run();
		start(3'h0, 1'b1);
		feed(1024, 12'h000);
		expect_update(4'h1);
		feed(1024, 12'h7ff);
		expect_update(4'he);
		chk_val(updates_r, u0 + 8'h02);
		chk_val(code_seen_r, 8'h0e);
		stop_run();
		// unsupported window fields
		for (int f = 5; f < 8; f++) begin
			start(f[2:0], 1'b1);
			feed(1100, 12'h7ff);
			@(posedge core_clk);
			#1;
			chk_bit(window_unsupported_r, 1'b1);
			chk_val(updates_r, u0 + 8'h02);
			stop_run();
		end
		// reset during the result latency flushes it
		start(3'h0, 1'b1);
		feed(1024, 12'h7ff);
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		chk_val(level_detect_r, 8'h00);
		chk_bit(window_unsupported_r, 1'b0);
		rst_n = 1'b1;
		repeat (6) begin
			@(posedge core_clk);
			#1;
			chk_bit(level_update_r, 1'b0);
		end
		stop_test();
	end
endmodule
